/* File: ias_pkg.sv */
// Package: constants, carriers and state type of the interrupt acceptance sequencer
package ias_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_ENABLE = 8'h00;
  localparam logic [7:0] OFF_LATCH = 8'h04;
  localparam logic [7:0] OFF_SELECT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  // Source levels; index 0 is the highest priority
  localparam int LVL_TRAP = 0;
  localparam int LVL_GUARD = 1;
  localparam int LVL_MASK_LO = 4;
  localparam int LVL_PAIR_A = 14;
  localparam int LVL_PAIR_B = 15;

  // Field positions
  localparam int IMF_POS = 0;
  localparam int SEL_PAIR_A = 0;
  localparam int SEL_PAIR_B = 1;
  localparam int STAT_BUSY_POS = 8;

  // Reset values and masks
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [15:0] LATCH_MASK = 16'hFFF3;
  localparam logic [11:0] EN_RST = 12'h000;
  localparam logic [1:0] SEL_RST = 2'h0;

  // Timing: acceptance and return each last this many machine cycles
  localparam int SEQ_MCYC = 8;

  // Vector table top; level n entry sits at VEC_TOP - 2n (low byte first)
  localparam logic [15:0] VEC_TOP = 16'hFFE0;
  localparam logic [7:0] TRAP_OPCODE = 8'hFF;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCEPT, ST_RETURN} ias_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ias_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ias_apb_rsp_s;

  typedef struct packed {
    logic lastCycle;
    logic retMask;
    logic retNonMask;
    logic trapExec;
  } ias_cpu_evt_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ias_mem_s;

  typedef struct packed {
    ias_state_e st;
    logic [7:0] cyc;
    logic masterIrqEnable;
    logic [11:0] perSourceEnable;
    logic [15:0] requestLatch;
    logic [1:0] sharedSourceSelector;
    logic [3:0] lvl;
    logic [3:0] lastLvl;
    logic [15:0] pcSave;
    logic [7:0] pswSave;
    logic [15:0] vec;
    ias_mem_s mem;
    logic pcLoad;
    logic [15:0] pcOut;
    logic pswLoad;
    logic spLoad;
    logic [15:0] spOut;
    logic apbAck;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] fetchByte;
  } ias_state_s;

endpackage : ias_pkg

/* File: ias_irq_accept_sequencer.sv */
// Interrupt acceptance, return sequencing and request latching with APB registers
// Function
// - Shared level latches only the selected source
// - Unselected shared requests are dropped, never remembered
// - Levels fourteen and fifteen are selector-arbitrated pairs
// - Latch holds until accepted, reset, or cleared
// - Acceptance takes exactly eight machine cycles
// - Acceptance first clears the master enable
// - Acceptance clears only the accepted source latch
// - Push status+enable, PC high, PC low; SP-3
// - Load vector table entry into program counter
// - Acceptance starts within 38 clocks of latching
// - Master enable zero blocks every maskable request
// - Only program counter and status are saved
// - Maskable and non-maskable returns end service
// - Stacked PC low at SP+1, high SP+2
// - Requests sampled in each instruction's last cycle
// - Trap opcode starts top-priority interrupt at once
// - Missing address fetch returns trap opcode FFH in single-chip mode
// - RAM or register-area fetch raises guard interrupt
// - Returns pop PC and status, restoring enable
// - Maskable needs own enable and master enable
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps

module ias_irq_accept_sequencer
#(
  parameter int MC_CLKS = 4,
  parameter logic [15:0] RAM_SFR_TOP = 16'h0FFF,
  parameter logic [15:0] ROM_BASE = 16'h4000
)
(
  input wire logic clock,                             // System clock
  input wire logic rst_n,                             // Synchronous reset, active low
  input wire ias_pkg::ias_apb_req_s apbReq,           // APB request
  output ias_pkg::ias_apb_rsp_s apbRsp,               // APB response
  input wire ias_pkg::ias_cpu_evt_s cpuEvt,           // Instruction pipeline events
  input wire logic [15:0] pcIn,                       // Current return address
  input wire logic [7:0] pswIn,                       // Current status word
  input wire logic [15:0] spIn,                       // Current stack pointer
  input wire logic [9:0] irqLevel,                    // Unshared maskable requests, levels 4..13
  input wire logic extIrqFour,                        // Shared pair A, external four
  input wire logic serialTransmitIrq,                 // Shared pair A, serial transmit
  input wire logic extIrqFive,                        // Shared pair B, external five
  input wire logic converterDoneIrq,                  // Shared pair B, converter done
  input wire logic fetchStrobe,                       // Instruction fetch pulse
  input wire logic [15:0] fetchAddr,                  // Instruction fetch address
  input wire logic [7:0] romData,                     // Byte from program memory
  input wire logic singleChip,                        // Single-chip mode level
  output logic [7:0] fetchByte,                       // Byte handed to the decoder
  output ias_pkg::ias_mem_s stackMem,                 // Stack and vector memory port
  input wire logic [7:0] memRdata,                    // Read data, one cycle after req
  output logic pcLoad,                                // Program counter load pulse
  output logic [15:0] pcOut,                          // Program counter value
  output logic pswLoad,                               // Status word load pulse
  output logic [7:0] pswOut,                          // Status word value
  output logic spLoad,                                // Stack pointer load pulse
  output logic [15:0] spOut,                          // Stack pointer value
  output logic busy                                   // Sequence in progress
);
  import ias_pkg::*;

  localparam logic [7:0] SEQ_LAST = 8'(SEQ_MCYC * MC_CLKS - 1);

  ias_state_s s;
  ias_state_s n;
  logic [15:0] sets;
  logic [15:0] latchClr;
  logic [15:0] accClr;
  logic [15:0] okMask;
  logic [15:0] pending;
  logic [4:0] pick;
  logic imfEff;
  logic mapped;
  logic wrNow;
  logic [31:0] rdVal;
  logic [15:0] vecAddr;
  logic fetchHole;

  function automatic logic [4:0] pickHighest(input logic [15:0] req);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--)
    begin
      if (req[i])
        r = {1'b1, 4'(i)};
    end
    return r;
  endfunction : pickHighest

  always_comb
  begin
    n = s;
    n.pcLoad = 1'b0;
    n.pswLoad = 1'b0;
    n.spLoad = 1'b0;
    n.mem.req = 1'b0;
    n.mem.we = 1'b0;
    n.apbAck = 1'b0;

    // Request sources; unselected partners of a shared level are simply not looked at
    sets = 16'h0000;
    sets[LVL_TRAP] = cpuEvt.trapExec;
    sets[LVL_GUARD] = fetchStrobe && (fetchAddr <= RAM_SFR_TOP);
    sets[LVL_PAIR_A - 1:LVL_MASK_LO] = irqLevel;
    sets[LVL_PAIR_A] = s.sharedSourceSelector[SEL_PAIR_A] ?
      serialTransmitIrq : extIrqFour;
    sets[LVL_PAIR_B] = s.sharedSourceSelector[SEL_PAIR_B] ?
      converterDoneIrq : extIrqFive;

    // Register file access
    mapped = (apbReq.paddr == OFF_ENABLE) || (apbReq.paddr == OFF_LATCH) ||
      (apbReq.paddr == OFF_SELECT) || (apbReq.paddr == OFF_STATUS);
    unique case (apbReq.paddr)
      OFF_ENABLE: rdVal = {16'h0000, s.perSourceEnable, 3'h0, s.masterIrqEnable};
      OFF_LATCH: rdVal = {16'h0000, s.requestLatch};
      OFF_SELECT: rdVal = {30'h00000000, s.sharedSourceSelector};
      OFF_STATUS: rdVal = {23'h000000, s.st != ST_IDLE, s.lvl, s.lastLvl};
      default: rdVal = 32'h00000000;
    endcase
    if (apbReq.psel && apbReq.penable && !s.apbAck)
    begin
      n.apbAck = 1'b1;
      n.pslverr = !mapped;
      n.prdata = mapped ? rdVal : 32'h00000000;
    end
    wrNow = apbReq.psel && apbReq.penable && apbReq.pwrite && s.apbAck && !s.pslverr;
    latchClr = 16'hFFFF;
    if (wrNow && apbReq.paddr == OFF_LATCH)
      latchClr = apbReq.pwdata[15:0];
    if (wrNow && apbReq.paddr == OFF_ENABLE)
    begin
      n.perSourceEnable = apbReq.pwdata[15:4];
      n.masterIrqEnable = apbReq.pwdata[IMF_POS];
    end
    if (wrNow && apbReq.paddr == OFF_SELECT)
      n.sharedSourceSelector = apbReq.pwdata[1:0];

    // During a return the enable about to be restored governs the sample
    imfEff = (s.st == ST_RETURN) ? s.pswSave[IMF_POS] : s.masterIrqEnable;
    okMask = {{12{imfEff}} & s.perSourceEnable, 4'b0011};
    pending = (s.requestLatch | sets) & okMask;
    pick = pickHighest(pending);
    vecAddr = VEC_TOP - {11'h000, s.lvl, 1'b0};
    accClr = 16'hFFFF;

    unique case (s.st)
      ST_IDLE:
      begin
        if (cpuEvt.retMask || cpuEvt.retNonMask)
        begin
          n.st = ST_RETURN;
          n.cyc = 8'h00;
        end
        else if (cpuEvt.lastCycle && pick[4])
        begin
          n.st = ST_ACCEPT;
          n.cyc = 8'h00;
          n.lvl = pick[3:0];
          n.masterIrqEnable = 1'b0;
          accClr[pick[3:0]] = 1'b0;
          n.pcSave = pcIn;
          n.pswSave = pswIn;
          n.pswSave[IMF_POS] = s.masterIrqEnable;
        end
      end
      ST_ACCEPT:
      begin
        n.cyc = s.cyc + 8'h01;
        n.masterIrqEnable = 1'b0;
        unique case (s.cyc)
          8'h00:
          begin
            // A chained start pushes at the stack pointer that the return is still loading
            n.mem = '{req: 1'b1, we: 1'b1, addr: s.spLoad ? s.spOut : spIn, wdata: s.pswSave};
          end
          8'h01:
          begin
            n.mem = '{req: 1'b1, we: 1'b1, addr: spIn - 16'h0001, wdata: s.pcSave[15:8]};
          end
          8'h02:
          begin
            n.mem = '{req: 1'b1, we: 1'b1, addr: spIn - 16'h0002, wdata: s.pcSave[7:0]};
            n.spLoad = 1'b1;
            n.spOut = spIn - 16'h0003;
          end
          8'h03:
          begin
            n.mem = '{req: 1'b1, we: 1'b0, addr: vecAddr, wdata: 8'h00};
          end
          8'h04:
          begin
            n.mem = '{req: 1'b1, we: 1'b0, addr: vecAddr + 16'h0001, wdata: 8'h00};
          end
          8'h05: n.vec[7:0] = memRdata;
          8'h06: n.vec[15:8] = memRdata;
          default: n.vec = s.vec;
        endcase
        if (s.cyc == SEQ_LAST)
        begin
          n.st = ST_IDLE;
          n.pcLoad = 1'b1;
          n.pcOut = s.vec;
          n.lastLvl = s.lvl;
        end
      end
      ST_RETURN:
      begin
        n.cyc = s.cyc + 8'h01;
        unique case (s.cyc)
          8'h00: n.mem = '{req: 1'b1, we: 1'b0, addr: spIn + 16'h0001, wdata: 8'h00};
          8'h01: n.mem = '{req: 1'b1, we: 1'b0, addr: spIn + 16'h0002, wdata: 8'h00};
          8'h02:
          begin
            n.mem = '{req: 1'b1, we: 1'b0, addr: spIn + 16'h0003, wdata: 8'h00};
            n.pcSave[7:0] = memRdata;
          end
          8'h03: n.pcSave[15:8] = memRdata;
          8'h04: n.pswSave = memRdata;
          default: n.pswSave = s.pswSave;
        endcase
        if (s.cyc == SEQ_LAST)
        begin
          n.pcLoad = 1'b1;
          n.pcOut = s.pcSave;
          n.pswLoad = 1'b1;
          n.spLoad = 1'b1;
          n.spOut = spIn + 16'h0003;
          n.masterIrqEnable = s.pswSave[IMF_POS];
          n.st = ST_IDLE;
          if (pick[4])
          begin
            n.st = ST_ACCEPT;
            n.cyc = 8'h00;
            n.lvl = pick[3:0];
            n.masterIrqEnable = 1'b0;
            accClr[pick[3:0]] = 1'b0;
            n.pcSave = s.pcSave;
            n.pswSave = s.pswSave;
          end
        end
      end
    endcase

    // New requests win over a software clear; the accepted level's own request is consumed
    n.requestLatch = (((s.requestLatch & latchClr) | sets) & accClr) & LATCH_MASK;

    fetchHole = (fetchAddr > RAM_SFR_TOP) && (fetchAddr < ROM_BASE);
    if (fetchStrobe)
      n.fetchByte = (singleChip && fetchHole) ? TRAP_OPCODE : romData;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.requestLatch <= LATCH_RST;
      s.perSourceEnable <= EN_RST;
      s.sharedSourceSelector <= SEL_RST;
    end
    else
      s <= n;
  end

  assign apbRsp.pready = s.apbAck;
  assign apbRsp.pslverr = s.apbAck && s.pslverr;
  assign apbRsp.prdata = s.prdata;
  assign stackMem = s.mem;
  assign pcLoad = s.pcLoad;
  assign pcOut = s.pcOut;
  assign pswLoad = s.pswLoad;
  assign pswOut = s.pswSave;
  assign spLoad = s.spLoad;
  assign spOut = s.spOut;
  assign fetchByte = s.fetchByte;
  assign busy = (s.st != ST_IDLE);

endmodule : ias_irq_accept_sequencer

/* File: ias_seq_chk_sva.sv */
// Checker: port-level properties of the acceptance sequencer
`timescale 1ns/1ps
module ias_seq_chk
  import ias_pkg::*;
#(
  parameter int MC_CLKS = 4,
  parameter logic [15:0] RAM_SFR_TOP = 16'h0FFF,
  parameter logic [15:0] ROM_BASE = 16'h4000
)
(
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset
  input wire ias_pkg::ias_apb_req_s apbReq, // APB request
  input wire ias_pkg::ias_apb_rsp_s apbRsp, // APB response
  input wire logic [15:0] pcIn, // Return address
  input wire logic [15:0] spIn, // Stack pointer in
  input wire logic fetchStrobe, // Fetch pulse
  input wire logic [15:0] fetchAddr, // Fetch address
  input wire logic [7:0] romData, // Program byte
  input wire logic singleChip, // Mode
  input wire logic [7:0] fetchByte, // Decoder byte
  input wire ias_pkg::ias_mem_s stackMem, // Stack port
  input wire logic pcLoad, // PC load
  input wire logic pswLoad, // Status load
  input wire logic spLoad, // SP load
  input wire logic [15:0] spOut, // SP value
  input wire logic busy // Sequence running
);
  logic [7:0] cnt_ff;
  logic busyPrev_ff;
  // Cycles since a sequence started; a chained start begins in the cycle of the load pulse
  always_ff @(posedge clock)
  begin
    busyPrev_ff <= rst_n & busy;
    cnt_ff <= (busy && (!busyPrev_ff || pcLoad)) ? 8'h01 : cnt_ff + 8'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  apb_one_wait_a: assert property ($rose(apbReq.penable) && apbReq.psel |-> !apbRsp.pready ##1 apbRsp.pready)
    else $error("pready not after one wait state");
  err_with_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0)
    else $error("pslverr without pready or with data");
  push_order_a: assert property (
    stackMem.req && stackMem.we && stackMem.addr == spIn |=>
    stackMem.req && stackMem.we && stackMem.addr == spIn - 16'h0001 && stackMem.wdata == pcIn[15:8] ##1
    stackMem.req && stackMem.we && stackMem.addr == spIn - 16'h0002 && stackMem.wdata == pcIn[7:0] &&
    spLoad && spOut == spIn - 16'h0003)
    else $error("push order or stack pointer wrong");
  ret_loads_a: assert property (pswLoad |-> pcLoad && spLoad && spOut == spIn + 16'h0003)
    else $error("return loads not together");
  seq_length_a: assert property (
    pcLoad |-> cnt_ff == 8'(SEQ_MCYC * MC_CLKS))
    else $error("sequence length wrong");
  mem_in_seq_a: assert property (stackMem.req |-> busy)
    else $error("stack access outside a sequence");
  trap_fill_a: assert property (
    fetchStrobe && singleChip && fetchAddr > RAM_SFR_TOP && fetchAddr < ROM_BASE |=> fetchByte == TRAP_OPCODE)
    else $error("hole fetch not trap opcode");
  rom_pass_a: assert property (fetchStrobe && fetchAddr >= ROM_BASE |=> fetchByte == $past(romData))
    else $error("program byte not passed");
endmodule : ias_seq_chk

bind ias_irq_accept_sequencer ias_seq_chk #(.MC_CLKS(MC_CLKS), .RAM_SFR_TOP(RAM_SFR_TOP), .ROM_BASE(ROM_BASE))
  u_chk (.clock(clock), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .pcIn(pcIn), .spIn(spIn),
  .fetchStrobe(fetchStrobe), .fetchAddr(fetchAddr), .romData(romData), .singleChip(singleChip),
  .fetchByte(fetchByte), .stackMem(stackMem), .pcLoad(pcLoad), .pswLoad(pswLoad), .spLoad(spLoad),
  .spOut(spOut), .busy(busy));

/* File: ias_cpu_model.sv */
// Partner model: CPU registers and stack memory
`timescale 1ns/1ps
module ias_cpu_model
  import ias_pkg::*;
(
  input wire logic clock, // Clock
  input wire ias_pkg::ias_mem_s stackMem, // Stack port
  output logic [7:0] memRdata, // Read data
  input wire logic pcLoad, // PC load
  input wire logic [15:0] pcOut, // PC value
  input wire logic pswLoad, // Status load
  input wire logic [7:0] pswOut, // Status value
  input wire logic spLoad, // SP load
  input wire logic [15:0] spOut, // SP value
  output logic [15:0] pcReg, // Program counter
  output logic [7:0] pswReg, // Status word
  output logic [15:0] spReg // Stack pointer
);
  logic [7:0] mem [0:65535];
  initial
  begin
    memRdata = 8'h00;
    pcReg = 16'h4100;
    pswReg = 8'h00;
    spReg = 16'h01FF;
  end
  always @(posedge clock)
  begin
    // Read data lasts one cycle, then a changing pattern
    memRdata <= (stackMem.req && !stackMem.we) ? mem[stackMem.addr] : ~memRdata;
    if (stackMem.req && stackMem.we)
      mem[stackMem.addr] <= stackMem.wdata;
    if (pcLoad)
      pcReg <= pcOut;
    if (pswLoad)
      pswReg <= pswOut;
    if (spLoad)
      spReg <= spOut;
  end
endmodule : ias_cpu_model

/* File: tb_irq_accept_sequencer.sv */
// Testbench: random and corner scenarios for the acceptance sequencer
`timescale 1ns/1ps
module tb_irq_accept_sequencer;
  import ias_pkg::*;
  localparam logic [17:0] EV_LAST = 18'h20000;
  localparam logic [17:0] EV_RETM = 18'h10000;
  localparam logic [17:0] EV_NONMASKABLE_RETURN_OP = 18'h08000;
  localparam logic [17:0] EV_TRAP = 18'h04000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  ias_apb_req_s apbReq = '0;
  ias_apb_rsp_s apbRsp;
  ias_mem_s stackMem;
  logic [17:0] pv = '0;
  logic [15:0] fetchAddr = '0;
  logic [7:0] romData = '0;
  logic fetchStrobe = 1'b0;
  logic singleChip = 1'b0;
  logic [7:0] fetchByte, memRdata, pswOut, pswIn, ps0, ed;
  logic pcLoad, pswLoad, spLoad, busy, err, sc, guard;
  logic [15:0] pcOut, spOut, pcIn, spIn, pc0, sp0, v4, v14, vt, newPc, a;
  logic [31:0] rd;
  integer seed = 32'h9970;
  integer fail_count = 0;
  integer total_checks = 0;
  integer i;
  always #4 clock = ~clock;
  ias_irq_accept_sequencer #(.MC_CLKS(1)) dut (.clock(clock), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .cpuEvt(pv[17:14]), .pcIn(pcIn), .pswIn(pswIn), .spIn(spIn), .irqLevel(pv[9:0]), .extIrqFour(pv[10]),
    .serialTransmitIrq(pv[11]), .extIrqFive(pv[12]), .converterDoneIrq(pv[13]), .fetchStrobe(fetchStrobe),
    .fetchAddr(fetchAddr), .romData(romData), .singleChip(singleChip), .fetchByte(fetchByte),
    .stackMem(stackMem), .memRdata(memRdata), .pcLoad(pcLoad), .pcOut(pcOut), .pswLoad(pswLoad),
    .pswOut(pswOut), .spLoad(spLoad), .spOut(spOut), .busy(busy));
  ias_cpu_model cpu (.clock(clock), .stackMem(stackMem), .memRdata(memRdata), .pcLoad(pcLoad), .pcOut(pcOut),
    .pswLoad(pswLoad), .pswOut(pswOut), .spLoad(spLoad), .spOut(spOut), .pcReg(pcIn), .pswReg(pswIn),
    .spReg(spIn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    @(posedge clock);
    while (apbRsp.pready !== 1'b1)
      @(posedge clock);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb
  task automatic pulse(input logic [17:0] v);
    @(posedge clock);
    pv <= v;
    @(posedge clock);
    pv <= '0;
  endtask : pulse
  task automatic wait_pc();
    @(negedge clock);
    while (pcLoad !== 1'b1)
      @(negedge clock);
  endtask : wait_pc
  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial
  begin
    #(8 * 30000);
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, OFF_ENABLE, 0); chk(rd, 0);
    apb(0, OFF_SELECT, 0); chk(rd, 0);
    apb(1, 8'h10, 32'hFFFFFFFF); chk(err, 1);
    $display("reset test done");
    pulse(18'h02800); apb(0, OFF_LATCH, 0); chk(rd, 0);
    apb(1, OFF_SELECT, 3); apb(0, OFF_LATCH, 0); chk(rd, 0);
    pulse(18'h02800); apb(1, OFF_SELECT, 0); apb(0, OFF_LATCH, 0); chk(rd, 32'hC000);
    apb(1, OFF_LATCH, 0); pulse(18'h01400); apb(0, OFF_LATCH, 0); chk(rd, 32'hC000);
    apb(1, OFF_LATCH, 32'h3FFF); pulse(18'h00401); apb(1, OFF_ENABLE, 32'h4010);
    pulse(EV_LAST); repeat (3) @(negedge clock); chk(busy, 0);
    $display("latch test done");
    pc0 = $random(seed); ps0 = $random(seed); v4 = $random(seed); v14 = $random(seed);
    cpu.pcReg <= pc0; cpu.pswReg <= ps0; sp0 = cpu.spReg;
    cpu.mem[VEC_TOP - 16'd8] = v4[7:0]; cpu.mem[VEC_TOP - 16'd7] = v4[15:8];
    cpu.mem[VEC_TOP - 16'd28] = v14[7:0]; cpu.mem[VEC_TOP - 16'd27] = v14[15:8];
    apb(1, OFF_ENABLE, 32'h4011); pulse(EV_LAST); wait_pc(); chk(pcOut, v4);
    chk(cpu.mem[sp0], {ps0[7:1], 1'b1}); chk(cpu.mem[sp0 - 16'd1], pc0[15:8]);
    chk(cpu.mem[sp0 - 16'd2], pc0[7:0]); chk(cpu.spReg, sp0 - 16'd3);
    apb(0, OFF_ENABLE, 0); chk(rd, 32'h4010);
    apb(0, OFF_LATCH, 0); chk(rd, 32'h4000);
    apb(0, OFF_STATUS, 0); chk(rd, 32'h00000044);
    pulse(EV_RETM); wait_pc(); chk(pcOut, pc0); chk(pswOut, {ps0[7:1], 1'b1});
    wait_pc(); chk(pcOut, v14);
    apb(1, OFF_ENABLE, 32'h0011);
    $display("accept test done");
    vt = $random(seed); newPc = $random(seed);
    cpu.mem[VEC_TOP] = vt[7:0]; cpu.mem[VEC_TOP + 16'd1] = vt[15:8];
    pulse(EV_LAST | EV_TRAP); wait_pc(); chk(pcOut, vt);
    cpu.mem[cpu.spReg + 16'd1] = newPc[7:0]; cpu.mem[cpu.spReg + 16'd2] = newPc[15:8];
    pulse(EV_NONMASKABLE_RETURN_OP); wait_pc(); chk(pcOut, newPc);
    $display("trap test done");
    guard = 1'b0;
    for (i = 0; i < 40; i++)
    begin
      a = (i == 0) ? 16'h0100 : (i == 1) ? 16'h3FFF : (i == 2) ? 16'h4000 : 16'($random(seed)) & 16'h7FFF;
      ed = $random(seed);
      sc = (i < 3) ? 1'b1 : 1'($random(seed));
      guard = guard | (a <= 16'h0FFF);
      @(posedge clock);
      fetchStrobe <= 1'b1; fetchAddr <= a; romData <= ed; singleChip <= sc;
      @(posedge clock);
      fetchStrobe <= 1'b0;
      @(negedge clock);
      if (a > 16'h0FFF)
        chk(fetchByte, (sc && a < 16'h4000) ? TRAP_OPCODE : ed);
    end
    apb(0, OFF_LATCH, 0); chk(rd[1], guard);
    apb(1, OFF_LATCH, 0); apb(0, OFF_LATCH, 0); chk(rd, 0);
    $display("fetch test done");
    complete_run();
  end
endmodule : tb_irq_accept_sequencer
